// *** rtl/compact_timer_defs.vh ***
// Register offsets, field positions and reset values of the compact timer
`ifndef COMPACT_TIMER_DEFS_VH
`define COMPACT_TIMER_DEFS_VH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CONTROL_A 6'h00
`define ADDR_CONTROL_B 6'h04
`define ADDR_COUNT_LOW 6'h08
`define ADDR_COUNT_HIGH 6'h0C
`define ADDR_DUTY_LOW 6'h10
`define ADDR_DUTY_HIGH 6'h14
`define ADDR_PERIOD 6'h18
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PAUSE_BIT 7
`define CKSEL_HI 6
`define CKSEL_LO 4
`define ON_BIT 3
`define MODE_HI 7
`define MODE_LO 6
`define OFUNC_HI 5
`define OFUNC_LO 4
`define OCTL_BIT 3
`define POL_BIT 2
`define SWAP_BIT 1
`define CLRSRC_BIT 0
`define CONTROL_A_MASK 8'hF8
// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define MODE_COMPARE 2'h0
`define MODE_PWM 2'h2
`define MODE_TIMER 2'h3
`define CK_SYS_DIV4 3'h0
`define CK_SYS 3'h1
`define CK_HIGH_DIV16 3'h2
`define CK_HIGH_DIV64 3'h3
`define CK_SUB_A 3'h4
`define CK_SUB_B 3'h5
`define CK_EXT_RISE 3'h6
`define CK_EXT_FALL 3'h7
`define RESET_BYTE 8'h00
`define SYS_DIV4_COUNT 4
`define HIGH_DIV16_COUNT 16
`define HIGH_DIV64_COUNT 64
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/compact_timer_module.v ***
// Compact 16-bit timer with comparators, output pins and AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_defs.vh"
module compact_timer_module #(
   parameter HIGH_DIV16 = `HIGH_DIV16_COUNT,
   parameter HIGH_DIV64 = `HIGH_DIV64_COUNT
) (
   input wire sys_clk,
   input wire resetn,
   input wire highClkTick,
   input wire subClkTick,
   input wire externalClockPin,
   output wire [1:0] timerOutputPins,
   output reg compareAEvent,
   output reg comparePEvent,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   reg [7:0] controlA_r;
   reg [7:0] controlB_r;
   reg [15:0] duty_r;
   reg [7:0] period_r;
   reg [7:0] bufWrite_r;
   reg [7:0] bufRead_r;
   reg [15:0] count_r;
   reg [15:0] count_nxt;
   reg outLevel_r;
   reg onPrev_r;
   wire onBit = controlA_r[`ON_BIT];
   wire pauseBit = controlA_r[`PAUSE_BIT];
   wire [2:0] clockSelectField = controlA_r[`CKSEL_HI:`CKSEL_LO];
   wire [1:0] modeSelectField = controlB_r[`MODE_HI:`MODE_LO];
   wire [1:0] outputFunctionField = controlB_r[`OFUNC_HI:`OFUNC_LO];
   wire outputControlBit = controlB_r[`OCTL_BIT];
   wire outputPolarityBit = controlB_r[`POL_BIT];
   wire dutyPeriodSwapBit = controlB_r[`SWAP_BIT];
   wire clearSourceBit = controlB_r[`CLRSRC_BIT];
   wire onRise = onBit & ~onPrev_r;

   // ------------------------------------------------------------------
   // External clock synchroniser
   // ------------------------------------------------------------------
   reg extSync1_r;
   reg extSync2_r;
   reg extSync3_r;
   reg extLevel_r;
   // Three stages; a level counts once stages two and three agree
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         extSync1_r <= 1'b0;
         extSync2_r <= 1'b0;
         extSync3_r <= 1'b0;
         extLevel_r <= 1'b0;
      end else begin
         extSync1_r <= externalClockPin;
         extSync2_r <= extSync1_r;
         extSync3_r <= extSync2_r;
         if (extSync2_r == extSync3_r) begin
            extLevel_r <= extSync3_r;
         end
      end
   end
   wire extNewLevel = (extSync2_r == extSync3_r) && (extSync3_r != extLevel_r);
   wire extRise = extNewLevel & extSync3_r;
   wire extFall = extNewLevel & ~extSync3_r;

   // ------------------------------------------------------------------
   // Clock dividers
   // ------------------------------------------------------------------
   localparam integer DIV16_LAST_I = HIGH_DIV16 - 1;
   localparam integer DIV64_LAST_I = HIGH_DIV64 - 1;
   localparam [5:0] DIV16_LAST = DIV16_LAST_I[5:0];
   localparam [5:0] DIV64_LAST = DIV64_LAST_I[5:0];
   reg [1:0] sysDiv_r;
   reg [5:0] div16_r;
   reg [5:0] div64_r;
   // Each divider wraps at its own count so both ratios stay exact
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sysDiv_r <= 2'h0;
         div16_r <= 6'h00;
         div64_r <= 6'h00;
      end else begin
         sysDiv_r <= sysDiv_r + 2'h1;
         if (highClkTick) begin
            div16_r <= (div16_r == DIV16_LAST) ? 6'h00 : div16_r + 6'h01;
            div64_r <= (div64_r == DIV64_LAST) ? 6'h00 : div64_r + 6'h01;
         end
      end
   end
   wire sysDiv4Tick = (sysDiv_r == 2'h3);
   wire high16Tick = highClkTick && (div16_r == DIV16_LAST);
   wire high64Tick = highClkTick && (div64_r == DIV64_LAST);

   reg countTick;
   always @* begin
      case (clockSelectField)
         `CK_SYS_DIV4: countTick = sysDiv4Tick;
         `CK_SYS: countTick = 1'b1;
         `CK_HIGH_DIV16: countTick = high16Tick;
         `CK_HIGH_DIV64: countTick = high64Tick;
         `CK_SUB_A: countTick = subClkTick;
         `CK_SUB_B: countTick = subClkTick;
         `CK_EXT_RISE: countTick = extRise;
         `CK_EXT_FALL: countTick = extFall;
         default: countTick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // Comparators and counter
   // ------------------------------------------------------------------
   // period top-byte match
   // Match one tick before the top byte reaches the value, so the
   // counter clears in place of that step and the period is exact
   wire [7:0] periodLast = period_r - 8'h01;
   wire matchP = (count_r[15:8] == periodLast) && (count_r[7:0] == 8'hFF);
   wire matchA = (count_r == duty_r);
   // zero period wraps periodLast to FF, full roll
   wire overflow = (count_r == 16'hFFFF);
   wire isPwm = (modeSelectField == `MODE_PWM);
   wire periodIsA = isPwm ? dutyPeriodSwapBit : clearSourceBit;
   wire runTick = onBit & ~pauseBit & countTick;
   wire endPeriodP = runTick & matchP;
   wire endPeriodA = runTick & matchA;

   always @* begin
      count_nxt = count_r;
      // on rise is the only software clear
      if (onRise) begin
         count_nxt = 16'h0000;
      // pause and off hold the count
      end else if (runTick) begin
         if (periodIsA ? matchA : matchP) begin
            count_nxt = 16'h0000;
         end else begin
            count_nxt = count_r + 16'h0001;
         end
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count_r <= 16'h0000;
         onPrev_r <= 1'b0;
         compareAEvent <= 1'b0;
         comparePEvent <= 1'b0;
      end else begin
         count_r <= count_nxt;
         onPrev_r <= onBit;
         compareAEvent <= endPeriodA & ~(overflow & duty_r == 16'h0000 & ~isPwm);
         comparePEvent <= endPeriodP & ~(clearSourceBit & ~isPwm);
      end
   end

   // ------------------------------------------------------------------
   // Output pin logic
   // ------------------------------------------------------------------
   // mode dependent output
   reg outLevel_nxt;
   always @* begin
      outLevel_nxt = outLevel_r;
      case (modeSelectField)
         `MODE_COMPARE: begin
            if (onRise) begin
               outLevel_nxt = outputControlBit;
            end else if (endPeriodA) begin
               case (outputFunctionField)
                  2'h1: outLevel_nxt = 1'b0;
                  2'h2: outLevel_nxt = 1'b1;
                  2'h3: outLevel_nxt = ~outLevel_r;
                  default: outLevel_nxt = outLevel_r;
               endcase
            end
         end
         `MODE_PWM: begin
            case (outputFunctionField)
               2'h0: outLevel_nxt = ~outputControlBit;
               2'h1: outLevel_nxt = outputControlBit;
               2'h2: outLevel_nxt = (count_nxt < (dutyPeriodSwapBit ?
                                     {period_r, 8'h00} : duty_r)) ?
                                     outputControlBit : ~outputControlBit;
               default: outLevel_nxt = outLevel_r;
            endcase
         end
         default: outLevel_nxt = outLevel_r;
      endcase
      if (!onBit) begin
         outLevel_nxt = outLevel_r;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         outLevel_r <= 1'b0;
      end else begin
         outLevel_r <= outLevel_nxt;
      end
   end
   // two pins, second one inverted by polarity
   // Timer mode disables both pins, polarity included
   wire isTimer = (modeSelectField == `MODE_TIMER);
   wire pinLevel = isTimer ? 1'b0 : outLevel_r;
   assign timerOutputPins[0] = pinLevel;
   assign timerOutputPins[1] = pinLevel ^ (outputPolarityBit & ~isTimer);

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   reg awHeld_r;
   reg wHeld_r;
   reg [5:0] awAddr_r;
   reg [7:0] wByte_r;
   reg wLane_r;
   // Address and data may arrive in either order; each is held until both are in
   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
   wire awTake = s_axi_awvalid & s_axi_awready;
   wire wTake = s_axi_wvalid & s_axi_wready;
   wire haveAw = awHeld_r | awTake;
   wire haveW = wHeld_r | wTake;
   wire [5:0] wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
   wire [7:0] wrByte = wHeld_r ? wByte_r : s_axi_wdata[7:0];
   wire wrLane = wHeld_r ? wLane_r : s_axi_wstrb[0];
   wire doWrite = haveAw & haveW;

   function mapped;
      input [5:0] addr;
      begin
         mapped = (addr[1:0] == 2'h0) && (addr <= `ADDR_PERIOD);
      end
   endfunction

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 6'h00;
         wByte_r <= 8'h00;
         wLane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         controlA_r <= `RESET_BYTE;
         controlB_r <= `RESET_BYTE;
         duty_r <= 16'h0000;
         period_r <= `RESET_BYTE;
         bufWrite_r <= `RESET_BYTE;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wrAddr) ? `RESP_OKAY : `RESP_SLVERR;
            if (wrLane) begin
               case (wrAddr)
                  `ADDR_CONTROL_A: controlA_r <= wrByte & `CONTROL_A_MASK;
                  `ADDR_CONTROL_B: controlB_r <= wrByte;
                  `ADDR_DUTY_LOW: bufWrite_r <= wrByte;
                  `ADDR_DUTY_HIGH: duty_r <= {wrByte, bufWrite_r};
                  `ADDR_PERIOD: period_r <= wrByte;
                  default: controlB_r <= controlB_r;
               endcase
            end
         end else begin
            if (awTake) begin
               awHeld_r <= 1'b1;
               awAddr_r <= s_axi_awaddr;
            end
            if (wTake) begin
               wHeld_r <= 1'b1;
               wByte_r <= s_axi_wdata[7:0];
               wLane_r <= s_axi_wstrb[0];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   // Low byte reads return the latch shared by count and duty
   assign s_axi_arready = ~s_axi_rvalid;
   wire arTake = s_axi_arvalid & s_axi_arready;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
         bufRead_r <= `RESET_BYTE;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
               `ADDR_CONTROL_A: s_axi_rdata[7:0] <= controlA_r & `CONTROL_A_MASK;
               `ADDR_CONTROL_B: s_axi_rdata[7:0] <= controlB_r;
               `ADDR_COUNT_LOW: s_axi_rdata[7:0] <= bufRead_r;
               `ADDR_COUNT_HIGH: begin
                  s_axi_rdata[7:0] <= count_r[15:8];
                  bufRead_r <= count_r[7:0];
               end
               `ADDR_DUTY_LOW: s_axi_rdata[7:0] <= bufRead_r;
               `ADDR_DUTY_HIGH: begin
                  s_axi_rdata[7:0] <= duty_r[15:8];
                  bufRead_r <= duty_r[7:0];
               end
               `ADDR_PERIOD: s_axi_rdata[7:0] <= period_r;
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // compact_timer_module
`default_nettype wire

// *** tb/compact_timer_properties.sv ***
// Concurrent checks on the compact timer ports
`timescale 1ns/100ps
`default_nettype none
module compact_timer_properties #(
   parameter HIGH_DIV16 = 16,
   parameter HIGH_DIV64 = 64
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic comparePEvent,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_ready_reset: assert property (
      $rose(resetn) |-> s_axi_awready && s_axi_wready && s_axi_arready)
      else $error("bus not ready after reset");
   a_wr_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rd_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   a_wr_refused: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rd_refused: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_wr_latency: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   a_rd_latency: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_byte_width: assert property (
      s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_resp_codes: assert property (
      s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
      else $error("illegal read response code");
   a_event_pulse: assert property (
      comparePEvent |=> !comparePEvent [*8])
      else $error("period event too close");
endmodule // compact_timer_properties
bind compact_timer_module compact_timer_properties #(
   .HIGH_DIV16(HIGH_DIV16),
   .HIGH_DIV64(HIGH_DIV64)
) compact_timer_properties_inst (.sys_clk, .resetn, .comparePEvent, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** tb/tb_compact_timer_module.sv ***
// Self-checking testbench of the compact timer
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_defs.vh"
module tb_compact_timer_module;
   localparam int D16 = 2;
   localparam int D64 = 4;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic highClkTick = 1'b1;
   logic subClkTick = 1'b0;
   logic [1:0] tickDiv = 2'h0;
   logic externalClockPin = 1'b0;
   logic [1:0] timerOutputPins;
   logic compareAEvent, comparePEvent;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int num_errors = 0;
   int n_compared = 0;
   compact_timer_module #(.HIGH_DIV16(D16), .HIGH_DIV64(D64)) compact_timer_module_inst (
      .sys_clk, .resetn, .highClkTick, .subClkTick, .externalClockPin, .timerOutputPins,
      .compareAEvent, .comparePEvent, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // High clock ticks every second cycle, sub clock every third
   always @(posedge sys_clk) begin
      tickDiv <= (tickDiv == 2'h2) ? 2'h0 : tickDiv + 2'h1;
      highClkTick <= ~highClkTick;
      subClkTick <= (tickDiv == 2'h2);
   end
   // ------------------------------------------------------------------
   // Checking, bus and stimulus tasks
   // ------------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic hang(input int i);
      if (i >= 5000) begin
         chk("wait bound", 32'h0, 32'h1);
         finish_test();
      end
   endtask
   // Handshakes are judged at the falling edge, where the values that the
   // next rising edge will see are settled; releases follow that rising edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      int i;
      logic awTk, wTk, done;
      logic [1:0] resp;
      done = 1'b0;
      resp = 2'h0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 5000; i++) begin
         @(negedge sys_clk);
         awTk = s_axi_awvalid & (s_axi_awready === 1'b1);
         wTk = s_axi_wvalid & (s_axi_wready === 1'b1);
         done = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge sys_clk);
         if (awTk) s_axi_awvalid <= 1'b0;
         if (wTk) s_axi_wvalid <= 1'b0;
         if (done) break;
      end
      s_axi_bready <= 1'b0;
      hang(i);
      chk("write response", `RESP_OKAY, resp);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
      int i;
      logic arTk, done;
      logic [31:0] data;
      logic [1:0] resp;
      done = 1'b0;
      data = 32'h0;
      resp = 2'h0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 5000; i++) begin
         @(negedge sys_clk);
         arTk = s_axi_arvalid & (s_axi_arready === 1'b1);
         done = (s_axi_rvalid === 1'b1);
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge sys_clk);
         if (arTk) s_axi_arvalid <= 1'b0;
         if (done) break;
      end
      s_axi_rready <= 1'b0;
      hang(i);
      chk("read response", er, resp);
      if (er == `RESP_OKAY) chk("read data", {24'h0, e}, data);
   endtask
   // High byte first so the low byte comes from the latch
   task automatic rdc(input logic [15:0] e);
      rd(`ADDR_COUNT_HIGH, e[15:8], `RESP_OKAY);
      rd(`ADDR_COUNT_LOW, e[7:0], `RESP_OKAY);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         externalClockPin <= 1'b1;
         repeat (4) @(posedge sys_clk);
         externalClockPin <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
   endtask
   task automatic waitEv(output int n);
      for (n = 1; n < 5000; n++) begin
         @(negedge sys_clk);
         if (comparePEvent === 1'b1) break;
      end
      hang(n);
   endtask
   function automatic int per(input int s);
      case (s)
         0: return `SYS_DIV4_COUNT * 256;
         2: return 2 * D16 * 256;
         3: return 2 * D64 * 256;
         4, 5: return 3 * 256;
         default: return 256;
      endcase
   endfunction
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      int n1, n2, n, s, nA, nP;
      logic [15:0] d;
      void'($urandom(32'h95BD));
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      for (s = 0; s < 7; s++) rd(6'(s * 4), 8'h00, `RESP_OKAY);
      rd(6'h1C, 8'h00, `RESP_SLVERR);
      wr(`ADDR_CONTROL_A, 8'hFF);
      rd(`ADDR_CONTROL_A, 8'hF8, `RESP_OKAY);
      d = 16'($urandom);
      wr(`ADDR_PERIOD, d[7:0]);
      rd(`ADDR_PERIOD, d[7:0], `RESP_OKAY);
      $display("test registers done");
      d = 16'($urandom);
      wr(`ADDR_DUTY_LOW, d[7:0]);
      rd(`ADDR_DUTY_HIGH, 8'h00, `RESP_OKAY);
      rd(`ADDR_DUTY_LOW, 8'h00, `RESP_OKAY);
      wr(`ADDR_DUTY_HIGH, d[15:8]);
      rd(`ADDR_DUTY_HIGH, d[15:8], `RESP_OKAY);
      rd(`ADDR_DUTY_LOW, d[7:0], `RESP_OKAY);
      $display("test duty pair done");
      n1 = 1 + $urandom % 8;
      n2 = 1 + $urandom % 8;
      wr(`ADDR_CONTROL_A, 8'h00);
      wr(`ADDR_CONTROL_A, 8'h68);
      rdc(16'h0000);
      pulse(n1);
      rdc(16'(n1));
      wr(`ADDR_CONTROL_A, 8'hE8);
      pulse(3);
      rdc(16'(n1));
      wr(`ADDR_CONTROL_A, 8'h78);
      pulse(n2);
      rdc(16'(n1 + n2));
      wr(`ADDR_CONTROL_A, 8'h70);
      pulse(2);
      rdc(16'(n1 + n2));
      wr(`ADDR_CONTROL_A, 8'h78);
      rdc(16'h0000);
      $display("test external count done");
      wr(`ADDR_CONTROL_A, 8'h00);
      wr(`ADDR_CONTROL_B, 8'h0C);
      wr(`ADDR_CONTROL_A, 8'h18);
      repeat (4) @(negedge sys_clk);
      chk("output pins", 32'h1, {30'h0, timerOutputPins});
      wr(`ADDR_CONTROL_B, 8'hCC);
      repeat (4) @(negedge sys_clk);
      chk("output pins", 32'h0, {30'h0, timerOutputPins});
      $display("test output pins done");
      wr(`ADDR_CONTROL_B, 8'h00);
      wr(`ADDR_PERIOD, 8'h01);
      for (s = 0; s < 6; s++) begin
         wr(`ADDR_CONTROL_A, 8'h00);
         wr(`ADDR_CONTROL_A, {1'b0, 3'(s), 1'b1, 3'b000});
         waitEv(n);
         waitEv(n);
         chk("event period", 32'(per(s)), 32'(n));
      end
      $display("test clock sources done");
      wr(`ADDR_CONTROL_A, 8'h00);
      wr(`ADDR_CONTROL_B, 8'h01);
      wr(`ADDR_DUTY_LOW, 8'h3F);
      wr(`ADDR_DUTY_HIGH, 8'h00);
      wr(`ADDR_CONTROL_A, 8'h18);
      nA = 0;
      nP = 0;
      repeat (300) begin
         @(negedge sys_clk);
         nA += (compareAEvent === 1'b1);
         nP += (comparePEvent === 1'b1);
      end
      chk("period events", 32'h0, 32'(nP));
      chk("duty events", 32'h1, {31'h0, nA >= 4});
      $display("test duty clear done");
      finish_test();
   end
endmodule // tb_compact_timer_module
`default_nettype wire
